// ==== dv/gyrnv_ctrl_assertions.sv ====
// Assertions on the register bank.
`timescale 1ns/1ns
module gyrnv_chk (
    // Clock, reset and register port
    input wire logic                   clock_i,
    input wire logic                   arst_n_i,
    input wire logic [7:0]             reg_addr_i,
    input wire logic [7:0]             reg_wdata_i,
    input wire logic                   reg_wr_i,
    input wire logic                   reg_rd_i,
    input wire logic [7:0]             reg_rdata_o,
    // Settings and events
    input wire logic                   y_high_o,
    input wire gyrnv_pkg::gyrnv_soc_t  soc_o,
    input wire gyrnv_pkg::gyrnv_foc_t  foc_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    localparam logic [15:0] TH_MAP = 16'ha521;
    wire        w_soc = reg_wr_i && reg_addr_i == 8'h31;
    wire        w_foc = reg_wr_i && reg_addr_i == 8'h32;
    wire        w_nvm = reg_wr_i && reg_addr_i == 8'h33;
    logic [7:0] wd_q;
    always_ff @(posedge clock_i) wd_q <= reg_wdata_i;
    a_soc_thresh: assert property (w_soc |=> soc_o.th_tenths == TH_MAP[wd_q[7:6]*4+:4])
        else $error("soc th");
    a_soc_time: assert property (w_soc |=> soc_o.dur_ms == 11'(40 << wd_q[5:3]))
        else $error("soc dur");
    a_soc_axes: assert property (w_soc |=> soc_o.en_zyx == wd_q[2:0])
        else $error("soc axes");
    a_avg_length: assert property (w_foc |=> foc_o.auto_len == 9'(32 << wd_q[7:6])
        && foc_o.fast_len == 9'(32 << wd_q[5:4])) else $error("avg len");
    a_start_pulse: assert property (w_foc && reg_wdata_i[3] |=> foc_o.start)
        else $error("no start");
    a_start_cause: assert property (foc_o.start |-> $past(w_foc && reg_wdata_i[3]))
        else $error("stray start");
    quick_cal_cfg_axes: assert property (w_foc |=> foc_o.en_zyx == wd_q[2:0])
        else $error("foc axes");
    a_load_busy: assert property ((w_nvm && reg_wdata_i[3]) ##2 (reg_rd_i
        && reg_addr_i == 8'h33) |=> !reg_rdata_o[2]) else $error("rdy in load");
    a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("rdata moved");
    c_start: cover property (w_foc && reg_wdata_i[3]);
    c_prog: cover property (w_nvm && reg_wdata_i[1]);
    c_event: cover property ($rose(y_high_o));
endmodule // gyrnv_chk
bind gyrnv_ctrl gyrnv_chk gyrnv_chk_i (.clock_i, .arst_n_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .y_high_o, .soc_o, .foc_o);

// ==== dv/gyrnv_host.sv ====
// Host model issuing single-byte register accesses.
`timescale 1ns/1ns
module gyrnv_host (
    // Clock
    input  wire logic       clock_i,
    // Register port
    output logic      [7:0] reg_addr_o,
    output logic      [7:0] reg_wdata_o,
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    input  wire logic [7:0] reg_rdata_i
);
    initial begin
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
    end
    task automatic wr(input logic [7:0] a, d);
        @(posedge clock_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        @(posedge clock_i);
        reg_wr_o <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        @(posedge clock_i);
        reg_rd_o <= 1'b0;
        #1 d = reg_rdata_i;
    endtask
    // Bounded poll, so a hang shows as a bad readback.
    task automatic wait_ready();
        logic [7:0] s = 8'h00;
        for (int n = 0; n < 40 && s[2] !== 1'b1; n++) rd(8'h33, s);
    endtask
endmodule // gyrnv_host

// ==== dv/tb.sv ====
// Self-checking bench for the register bank.
`timescale 1ns/1ns
module tb;
    logic                   clock_i, arst_n_i, sel, wr, rd, y_high;
    logic [7:0]             addr, wdata, rdata, d;
    gyrnv_pkg::gyrnv_axis_t y_ax, z_ax;
    logic signed [16:0]     y_cf, y_cu, z_cf, z_cu;
    int                     miscompares = 0, n_compared = 0;
    localparam logic [7:0]  RA [8] = '{8'h24, 8'h25, 8'h26, 8'h27, 8'h31, 8'h32, 8'h33, 8'h28};
    localparam logic [7:0]  RV [8] = '{8'h02, 8'h19, 8'h02, 8'h19, 8'h60, 8'hc0, 8'ha4, 8'h00};
    gyrnv_ctrl #(.DUR_TICK_CYC(8), .NVM_PROG_CYC(4)) gyrnv_ctrl_i (.clock_i, .arst_n_i,
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .y_axis_i(y_ax), .z_axis_i(z_ax), .high_unfilt_sel_i(sel),
        .y_corr_filt_o(y_cf), .y_corr_unfilt_o(y_cu), .z_corr_filt_o(z_cf),
        .z_corr_unfilt_o(z_cu), .y_high_o(y_high), .z_high_o(), .soc_o(), .foc_o());
    gyrnv_host gyrnv_host_i (.clock_i, .reg_addr_o(addr), .reg_wdata_o(wdata),
        .reg_wr_o(wr), .reg_rd_o(rd), .reg_rdata_i(rdata));
    task automatic check(input logic [16:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic put(input logic [7:0] a, d);
        gyrnv_host_i.wr(a, d);
    endtask
    task automatic rchk(input logic [7:0] a, e);
        gyrnv_host_i.rd(a, d);
        check(17'(d), 17'(e));
    endtask
    task automatic report_and_stop();
        $display("cmp=%0d err=%0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end
    initial begin
        #200000;
        miscompares++;
        report_and_stop();
    end
    initial begin
        arst_n_i = 1'b0;
        sel = 1'b1;
        y_ax = '0;
        z_ax = '0;
        repeat (5) @(posedge clock_i);
        arst_n_i <= 1'b1;
        for (int i = 0; i < 8; i++) rchk(RA[i], RV[i]);
        for (int c = 0; c < 8; c++) begin
            put(8'h31, 8'(c * 73));
            put(8'h32, 8'(c * 85));
        end
        put(8'h32, 8'h5e);
        rchk(8'h32, 8'h56);
        put(8'h24, 8'h03);
        put(8'h25, 8'h00);
        y_ax <= '{filt: 16'sd3000, unfilt: 16'sd0, offset: -12'sd5};
        z_ax <= '{filt: 16'sd7, unfilt: -16'sd9, offset: 12'sd2};
        repeat (40) @(posedge clock_i);
        check(17'(y_high), 17'h0);
        check(y_cf, 17'sd3005);
        check(y_cu, 17'sd5);
        check(z_cu, -17'sd11);
        y_ax <= '{filt: 16'sd0, unfilt: 16'sd3000, offset: 12'sd0};
        for (int n = 0; n < 40 && y_high !== 1'b1; n++) @(posedge clock_i);
        check(17'(y_high), 17'h1);
        y_ax.unfilt <= 16'sd1500;
        repeat (40) @(posedge clock_i);
        check(17'(y_high), 17'h1);
        y_ax.unfilt <= 16'sd1000;
        repeat (3) @(posedge clock_i);
        check(17'(y_high), 17'h0);
        put(8'h33, 8'h02);
        rchk(8'h33, 8'ha4);
        put(8'h33, 8'h01);
        gyrnv_host_i.wait_ready();
        put(8'h33, 8'h03);
        rchk(8'h33, 8'h91);
        put(8'h24, 8'h55);
        gyrnv_host_i.wait_ready();
        rchk(8'h24, 8'h03);
        put(8'h24, 8'haa);
        put(8'h33, 8'h09);
        rchk(8'h33, 8'h99);
        gyrnv_host_i.wait_ready();
        rchk(8'h24, 8'h03);
        for (int k = 0; k < 9; k++) begin
            gyrnv_host_i.wait_ready();
            put(8'h33, 8'h03);
        end
        gyrnv_host_i.wait_ready();
        rchk(8'h33, 8'h05);
        put(8'h33, 8'h03);
        rchk(8'h33, 8'h05);
        report_and_stop();
    end
endmodule // tb

// ==== verilog/gyrnv_ctrl.sv ====
// Register bank for y/z high-rate, offset cancellation and NVM control, with its NVM sequencer.
`timescale 1ns/1ns

// How it works
// - Y and z thresholds are (255 + 256 * field) * 4 LSB, 5-bit field.
// - Hysteresis uses the same formula on a 2-bit field; levels follow range.
// - Bit 0 of each threshold register enables high-rate detection for its axis.
// - Duration is (1 + field) * 2.5 ms, counted in tick pulses.
// - Drift threshold codes 0..3 give 0.1, 0.2, 0.5, 1 deg/s.
// - Drift duration codes 0..5 give 40..1280 ms; codes 6, 7 unused.
// - Three bits enable drift cancellation per axis x, y, z.
// - Both averaging lengths give 32, 64, 128, 256 samples for codes 0..3.
// - Writing one to bit 3 starts a quick calibration of enabled axes.
// - Three bits include axes x, y, z in the quick calibration.
// - Read-only 4-bit remaining count drops by one per accepted program.
// - Writing one to the reload bit refreshes all config registers from NVM.
// - Ready reads zero during program or reload, one otherwise.
// - Program trigger taken only when unlocked and remaining count above zero.
// - Unlock bit 0 permits programming when one, blocks it when zero.
// - Stored per-axis offsets are subtracted from filtered and unfiltered data.
// - Source bit picks unfiltered (one) or filtered (zero) data for detection.
module gyrnv_ctrl #(
    parameter int DUR_TICK_CYC = gyrnv_pkg::DUR_TICK_CYC,
    parameter int NVM_PROG_CYC = gyrnv_pkg::NVM_PROG_CYC
) (
    // Clock and reset
    input  wire logic                   clock_i,
    input  wire logic                   arst_n_i,
    // Register port from the serial interface
    input  wire logic [7:0]             reg_addr_i,
    input  wire logic [7:0]             reg_wdata_i,
    input  wire logic                   reg_wr_i,
    input  wire logic                   reg_rd_i,
    output logic      [7:0]             reg_rdata_o,
    // Sensor data
    input  wire gyrnv_pkg::gyrnv_axis_t y_axis_i,
    input  wire gyrnv_pkg::gyrnv_axis_t z_axis_i,
    input  wire logic                   high_unfilt_sel_i,
    // Corrected data and events
    output logic signed [16:0]          y_corr_filt_o,
    output logic signed [16:0]          y_corr_unfilt_o,
    output logic signed [16:0]          z_corr_filt_o,
    output logic signed [16:0]          z_corr_unfilt_o,
    output logic                        y_high_o,
    output logic                        z_high_o,
    // Offset cancellation settings
    output gyrnv_pkg::gyrnv_soc_t       soc_o,
    output gyrnv_pkg::gyrnv_foc_t       foc_o
);

    // ****************************************
    // Declarations
    // ****************************************
    localparam int TICK_W = $clog2(DUR_TICK_CYC + 1);
    localparam int WAIT_W = $clog2(NVM_PROG_CYC + 1);

    gyrnv_pkg::gyrnv_state_t state;
    gyrnv_pkg::gyrnv_state_t next_state;

    logic [7:0]        cfg [0:gyrnv_pkg::NUM_IMG-1];
    logic [2:0]        wr_idx;
    logic              host_wr;
    logic              nvm_wr;
    logic              load_go;
    logic              prog_go;
    logic              ready;
    logic              unlock;
    logic [3:0]        remain;
    logic [2:0]        ptr;
    logic              ld_v;
    logic [2:0]        ld_idx;
    logic [WAIT_W-1:0] wait_cnt;
    logic [TICK_W-1:0] tick_cnt;
    logic              tick;
    logic              foc_start;
    logic              mem_wr;
    logic              mem_rd;
    logic [2:0]        img_ptr;
    logic [7:0]        mem_rdata;

    // ****************************************
    // Host access decode
    // ****************************************
    assign wr_idx  = gyrnv_pkg::addr_idx(reg_addr_i);
    assign host_wr = reg_wr_i && (wr_idx < 3'(gyrnv_pkg::NUM_IMG));
    assign nvm_wr  = reg_wr_i && (wr_idx == gyrnv_pkg::IDX_NVM);
    assign ready   = (state == gyrnv_pkg::ST_IDLE);

    // A trigger while busy is dropped; the host is expected to poll ready first.
    assign load_go = nvm_wr && ready && reg_wdata_i[gyrnv_pkg::NVM_LOAD_BIT];
    assign prog_go = nvm_wr && ready && !load_go
                   && reg_wdata_i[gyrnv_pkg::NVM_TRIG_BIT]
                   && unlock && (remain != 4'h0);

    // ****************************************
    // Configuration registers
    // ****************************************
    // A reload write in the same cycle as a host write wins, since it is the newer image.
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < gyrnv_pkg::NUM_IMG; i++) begin
                cfg[i] <= gyrnv_pkg::img_rst(i);
            end
        end else if (ld_v) begin
            cfg[ld_idx] <= mem_rdata;
        end else if (host_wr && ready) begin
            cfg[wr_idx] <= reg_wdata_i;
        end
    end

    // ****************************************
    // Quick calibration start pulse
    // ****************************************
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            foc_start <= 1'b0;
        end else begin
            foc_start <= host_wr && (wr_idx == gyrnv_pkg::IDX_FOC)
                       && reg_wdata_i[gyrnv_pkg::FOC_START_BIT];
        end
    end

    // ****************************************
    // NVM lock and remaining count
    // ****************************************
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            unlock <= 1'b0;
        end else if (nvm_wr) begin
            unlock <= reg_wdata_i[gyrnv_pkg::NVM_OPEN_BIT];
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            remain <= gyrnv_pkg::RST_REMAIN;
        end else if (prog_go) begin
            remain <= remain - 4'h1;
        end
    end

    // ****************************************
    // NVM sequencer
    // ****************************************
    always_comb begin
        next_state = state;
        case (state)
            gyrnv_pkg::ST_IDLE: begin
                if (load_go) begin
                    next_state = gyrnv_pkg::ST_LOAD;
                end else if (prog_go) begin
                    next_state = gyrnv_pkg::ST_PROG;
                end
            end
            gyrnv_pkg::ST_LOAD: begin
                if (ptr == 3'(gyrnv_pkg::NUM_IMG)) begin
                    next_state = gyrnv_pkg::ST_IDLE;
                end
            end
            gyrnv_pkg::ST_PROG: begin
                if (ptr == 3'(gyrnv_pkg::NUM_IMG - 1)) begin
                    next_state = gyrnv_pkg::ST_WAIT;
                end
            end
            gyrnv_pkg::ST_WAIT: begin
                if (wait_cnt == WAIT_W'(NVM_PROG_CYC - 1)) begin
                    next_state = gyrnv_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = gyrnv_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= gyrnv_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ptr <= '0;
        end else if (next_state != state) begin
            ptr <= '0;
        end else if (state == gyrnv_pkg::ST_LOAD || state == gyrnv_pkg::ST_PROG) begin
            ptr <= ptr + 3'h1;
        end
    end

    // The cell wear time after the image is written keeps ready low for a realistic span.
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wait_cnt <= '0;
        end else if (state == gyrnv_pkg::ST_WAIT) begin
            wait_cnt <= wait_cnt + WAIT_W'(1);
        end else begin
            wait_cnt <= '0;
        end
    end

    // Read data lag the address by one cycle, so the write-back index is delayed alongside.
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ld_v   <= 1'b0;
            ld_idx <= '0;
        end else begin
            ld_v   <= mem_rd;
            ld_idx <= img_ptr;
        end
    end

    assign mem_rd  = (state == gyrnv_pkg::ST_LOAD) && (ptr < 3'(gyrnv_pkg::NUM_IMG));
    assign mem_wr  = (state == gyrnv_pkg::ST_PROG);
    assign img_ptr = (ptr < 3'(gyrnv_pkg::NUM_IMG)) ? ptr : 3'h0;

    gyrnv_img_mem #(
        .WIDTH (8),
        .DEPTH (gyrnv_pkg::NUM_IMG)
    ) u_img (
        .clock_i   (clock_i),
        .arst_n_i  (arst_n_i),
        .wr_en_i   (mem_wr),
        .wr_addr_i (img_ptr),
        .wr_data_i (cfg[img_ptr]),
        .rd_en_i   (mem_rd),
        .rd_addr_i (img_ptr),
        .rd_data_o (mem_rdata)
    );

    // ****************************************
    // Register read-back
    // ****************************************
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= '0;
        end else if (reg_rd_i) begin
            case (wr_idx)
                gyrnv_pkg::IDX_Y_TH,
                gyrnv_pkg::IDX_Y_DUR,
                gyrnv_pkg::IDX_Z_TH,
                gyrnv_pkg::IDX_Z_DUR,
                gyrnv_pkg::IDX_SOC: begin
                    reg_rdata_o <= cfg[wr_idx];
                end
                gyrnv_pkg::IDX_FOC: begin
                    reg_rdata_o <= cfg[gyrnv_pkg::IDX_FOC] & 8'hf7;
                end
                gyrnv_pkg::IDX_NVM: begin
                    reg_rdata_o <= {remain,
                                    state == gyrnv_pkg::ST_LOAD,
                                    ready,
                                    1'b0,
                                    unlock};
                end
                default: begin
                    reg_rdata_o <= 8'h00;
                end
            endcase
        end
    end

    // ****************************************
    // Duration tick divider
    // ****************************************
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end else if (tick_cnt == TICK_W'(DUR_TICK_CYC - 1)) begin
            tick_cnt <= '0;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + TICK_W'(1);
            tick     <= 1'b0;
        end
    end

    // ****************************************
    // Axis detectors
    // ****************************************
    gyrnv_rate_axis u_y (
        .clock_i       (clock_i),
        .arst_n_i      (arst_n_i),
        .tick_i        (tick),
        .axis_i        (y_axis_i),
        .unfilt_sel_i  (high_unfilt_sel_i),
        .en_i          (cfg[gyrnv_pkg::IDX_Y_TH][gyrnv_pkg::TH_EN_BIT]),
        .th_code_i     (cfg[gyrnv_pkg::IDX_Y_TH][gyrnv_pkg::TH_LSB +: 5]),
        .hy_code_i     (cfg[gyrnv_pkg::IDX_Y_TH][gyrnv_pkg::HY_LSB +: 2]),
        .dur_code_i    (cfg[gyrnv_pkg::IDX_Y_DUR]),
        .corr_filt_o   (y_corr_filt_o),
        .corr_unfilt_o (y_corr_unfilt_o),
        .high_o        (y_high_o)
    );

    gyrnv_rate_axis u_z (
        .clock_i       (clock_i),
        .arst_n_i      (arst_n_i),
        .tick_i        (tick),
        .axis_i        (z_axis_i),
        .unfilt_sel_i  (high_unfilt_sel_i),
        .en_i          (cfg[gyrnv_pkg::IDX_Z_TH][gyrnv_pkg::TH_EN_BIT]),
        .th_code_i     (cfg[gyrnv_pkg::IDX_Z_TH][gyrnv_pkg::TH_LSB +: 5]),
        .hy_code_i     (cfg[gyrnv_pkg::IDX_Z_TH][gyrnv_pkg::HY_LSB +: 2]),
        .dur_code_i    (cfg[gyrnv_pkg::IDX_Z_DUR]),
        .corr_filt_o   (z_corr_filt_o),
        .corr_unfilt_o (z_corr_unfilt_o),
        .high_o        (z_high_o)
    );

    // ****************************************
    // Offset cancellation settings
    // ****************************************
    // Drift duration codes 6 and 7 are not blocked; they wrap to 512 and 1024 ms and must not be used.
    always_comb begin
        soc_o.th_tenths = gyrnv_pkg::soc_th_tenths(
                              cfg[gyrnv_pkg::IDX_SOC][gyrnv_pkg::SOC_TH_LSB +: 2]);
        soc_o.dur_ms    = 11'(gyrnv_pkg::SOC_DUR_MS0
                              << cfg[gyrnv_pkg::IDX_SOC][gyrnv_pkg::SOC_DUR_LSB +: 3]);
        soc_o.en_zyx    = cfg[gyrnv_pkg::IDX_SOC][2:0];
        foc_o.auto_len  = gyrnv_pkg::avg_len(
                              cfg[gyrnv_pkg::IDX_FOC][gyrnv_pkg::FOC_AUTO_LSB +: 2]);
        foc_o.fast_len  = gyrnv_pkg::avg_len(
                              cfg[gyrnv_pkg::IDX_FOC][gyrnv_pkg::FOC_FAST_LSB +: 2]);
        foc_o.en_zyx    = cfg[gyrnv_pkg::IDX_FOC][2:0];
        foc_o.start     = foc_start;
    end

endmodule // gyrnv_ctrl

// ==== verilog/gyrnv_img_mem.sv ====
// Non-volatile image store of the configuration registers with registered read data.
`timescale 1ns/1ns
module gyrnv_img_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 6
) (
    // Clock and reset
    input  wire logic                     clock_i,
    input  wire logic                     arst_n_i,
    // Write side
    input  wire logic                     wr_en_i,
    input  wire logic [2:0]               wr_addr_i,
    input  wire logic [WIDTH-1:0]         wr_data_i,
    // Read side
    input  wire logic                     rd_en_i,
    input  wire logic [2:0]               rd_addr_i,
    output logic      [WIDTH-1:0]         rd_data_o
);

    logic [WIDTH-1:0] mem [0:DEPTH-1];

    // The image starts out holding the register reset values, standing in for factory content.
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= WIDTH'(gyrnv_pkg::img_rst(i));
            end
        end else if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_data_o <= '0;
        end else if (rd_en_i) begin
            rd_data_o <= mem[rd_addr_i];
        end
    end

endmodule // gyrnv_img_mem

// ==== verilog/gyrnv_pkg.sv ====
// Package of constants and types for the rate-interrupt and offset/NVM register bank.
package gyrnv_pkg;

    // ****************************************
    // Register offsets and indices
    // ****************************************
    localparam logic [7:0] ADDR_Y_TH  = 8'h24;
    localparam logic [7:0] ADDR_Y_DUR = 8'h25;
    localparam logic [7:0] ADDR_Z_TH  = 8'h26;
    localparam logic [7:0] ADDR_Z_DUR = 8'h27;
    localparam logic [7:0] ADDR_SOC   = 8'h31;
    localparam logic [7:0] ADDR_FOC   = 8'h32;
    localparam logic [7:0] ADDR_NVM   = 8'h33;

    localparam logic [2:0] IDX_Y_TH  = 3'h0;
    localparam logic [2:0] IDX_Y_DUR = 3'h1;
    localparam logic [2:0] IDX_Z_TH  = 3'h2;
    localparam logic [2:0] IDX_Z_DUR = 3'h3;
    localparam logic [2:0] IDX_SOC   = 3'h4;
    localparam logic [2:0] IDX_FOC   = 3'h5;
    localparam logic [2:0] IDX_NVM   = 3'h6;
    localparam logic [2:0] IDX_NONE  = 3'h7;
    localparam int         NUM_IMG   = 6;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] RST_TH     = 8'h02;
    localparam logic [7:0] RST_DUR    = 8'h19;
    localparam logic [7:0] RST_SOC    = 8'h60;
    localparam logic [7:0] RST_FOC    = 8'hc0;
    localparam logic [3:0] RST_REMAIN = 4'ha;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int TH_EN_BIT     = 0;
    localparam int TH_LSB        = 1;
    localparam int HY_LSB        = 6;
    localparam int SOC_TH_LSB    = 6;
    localparam int SOC_DUR_LSB   = 3;
    localparam int FOC_AUTO_LSB  = 6;
    localparam int FOC_FAST_LSB  = 4;
    localparam int FOC_START_BIT = 3;
    localparam int NVM_LOAD_BIT  = 3;
    localparam int NVM_TRIG_BIT  = 1;
    localparam int NVM_OPEN_BIT  = 0;

    // ****************************************
    // Level formula and timing
    // ****************************************
    localparam int HR_BASE      = 255;
    localparam int HR_STEP      = 256;
    localparam int HR_SCALE     = 4;
    localparam int CLK_MHZ      = 250;
    localparam int DUR_STEP_US  = 2500;
    localparam int DUR_TICK_CYC = DUR_STEP_US * CLK_MHZ;
    localparam int NVM_PROG_US  = 10;
    localparam int NVM_PROG_CYC = NVM_PROG_US * CLK_MHZ;
    localparam int SOC_DUR_MS0  = 40;
    localparam int AVG_LEN0     = 32;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic signed [15:0] filt;
        logic signed [15:0] unfilt;
        logic signed [11:0] offset;
    } gyrnv_axis_t;

    typedef struct packed {
        logic [3:0]  th_tenths;
        logic [10:0] dur_ms;
        logic [2:0]  en_zyx;
    } gyrnv_soc_t;

    typedef struct packed {
        logic [8:0] auto_len;
        logic [8:0] fast_len;
        logic [2:0] en_zyx;
        logic       start;
    } gyrnv_foc_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01,
        ST_PROG = 2'b11,
        ST_WAIT = 2'b10
    } gyrnv_state_t;

    // ****************************************
    // Functions
    // ****************************************
    function automatic logic [15:0] hr_level(input logic [4:0] code);
        hr_level = 16'((HR_BASE + HR_STEP * int'(code)) * HR_SCALE);
    endfunction

    function automatic logic [7:0] img_rst(input int idx);
        case (idx)
            0, 2:    img_rst = RST_TH;
            1, 3:    img_rst = RST_DUR;
            4:       img_rst = RST_SOC;
            default: img_rst = RST_FOC;
        endcase
    endfunction

    function automatic logic [2:0] addr_idx(input logic [7:0] addr);
        case (addr)
            ADDR_Y_TH:  addr_idx = IDX_Y_TH;
            ADDR_Y_DUR: addr_idx = IDX_Y_DUR;
            ADDR_Z_TH:  addr_idx = IDX_Z_TH;
            ADDR_Z_DUR: addr_idx = IDX_Z_DUR;
            ADDR_SOC:   addr_idx = IDX_SOC;
            ADDR_FOC:   addr_idx = IDX_FOC;
            ADDR_NVM:   addr_idx = IDX_NVM;
            default:    addr_idx = IDX_NONE;
        endcase
    endfunction

    function automatic logic [3:0] soc_th_tenths(input logic [1:0] code);
        case (code)
            2'h0:    soc_th_tenths = 4'h1;
            2'h1:    soc_th_tenths = 4'h2;
            2'h2:    soc_th_tenths = 4'h5;
            default: soc_th_tenths = 4'ha;
        endcase
    endfunction

    function automatic logic [8:0] avg_len(input logic [1:0] code);
        avg_len = 9'(AVG_LEN0 << code);
    endfunction

endpackage

// ==== verilog/gyrnv_rate_axis.sv ====
// One axis of offset subtraction and high-rate detection.
`timescale 1ns/1ns
module gyrnv_rate_axis (
    // Clock and reset
    input  wire logic                 clock_i,
    input  wire logic                 arst_n_i,
    input  wire logic                 tick_i,
    // Sensor data
    input  wire gyrnv_pkg::gyrnv_axis_t axis_i,
    input  wire logic                 unfilt_sel_i,
    // Settings
    input  wire logic                 en_i,
    input  wire logic [4:0]           th_code_i,
    input  wire logic [1:0]           hy_code_i,
    input  wire logic [7:0]           dur_code_i,
    // Results
    output logic signed [16:0]        corr_filt_o,
    output logic signed [16:0]        corr_unfilt_o,
    output logic                      high_o
);

    logic [15:0] th;
    logic [15:0] hy;
    logic [15:0] rel;
    logic [16:0] mag;
    logic [8:0]  cnt;

    // Levels are in LSB of the data path, so they follow the range setting by themselves.
    assign th  = gyrnv_pkg::hr_level(th_code_i);
    assign hy  = gyrnv_pkg::hr_level({3'h0, hy_code_i});
    assign rel = (th > hy) ? th - hy : 16'h0000;

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            corr_filt_o   <= '0;
            corr_unfilt_o <= '0;
        end else begin
            corr_filt_o   <= 17'(axis_i.filt) - 17'(axis_i.offset);
            corr_unfilt_o <= 17'(axis_i.unfilt) - 17'(axis_i.offset);
        end
    end

    always_comb begin
        logic signed [16:0] src;
        src = unfilt_sel_i ? corr_unfilt_o : corr_filt_o;
        mag = src[16] ? 17'(-src) : src;
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt    <= '0;
            high_o <= 1'b0;
        end else if (!en_i) begin
            cnt    <= '0;
            high_o <= 1'b0;
        end else if (high_o) begin
            cnt <= '0;
            if (mag < {1'b0, rel}) begin
                high_o <= 1'b0;
            end
        end else if (mag > {1'b0, th}) begin
            if (tick_i) begin
                if (cnt >= {1'b0, dur_code_i}) begin
                    high_o <= 1'b1;
                end else begin
                    cnt <= cnt + 9'h001;
                end
            end
        end else begin
            cnt <= '0;
        end
    end

endmodule // gyrnv_rate_axis
